// *** include/pccard_pkg.sv ***
/*
  Shared constants and types for the 16-bit card strobe controller:
  command codes, sequencer states, widths and timing counts.
  Assumes a single 125 MHz clock domain and active-low card pins.
*/

package pccard_pkg;

  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 8;
  localparam int WAIT_W     = 16;

  // Access timing, in ns, then in whole clock cycles (setup, strobe, hold rounded up; wait limit rounded down)
  localparam int CLK_NS      = 8;
  localparam int SETUP_NS    = 30;
  localparam int STROBE_NS   = 150;
  localparam int HOLD_NS     = 30;
  localparam int WAIT_MAX_NS = 12000;

  localparam logic [CNT_W-1:0]  SETUP_CYC    = CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0]  STROBE_CYC   = CNT_W'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0]  HOLD_CYC     = CNT_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WAIT_W-1:0] WAIT_MAX_CYC = WAIT_W'(WAIT_MAX_NS / CLK_NS);

  // Idle level of the synchronised card inputs: acknowledge, ready, wait
  localparam logic [2:0]        PIN_IDLE     = 3'h7;
  localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000;

  typedef enum logic [2:0] {
    CMD_MEM_RD      = 3'h0,
    CMD_MEM_WR      = 3'h1,
    CMD_ATTR_RD     = 3'h2,
    CMD_ATTR_WR     = 3'h3,
    CMD_IO_RD       = 3'h4,
    CMD_IO_WR       = 3'h5,
    CMD_DMA_TO_HOST = 3'h6,
    CMD_DMA_TO_CARD = 3'h7
  } cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } state_t;

endpackage

// *** sim/card_model.sv ***
/*
  Behavioural 16-bit card on the far side of the socket.
  Assumes the bench steers busy, interrupt, DMA request and wait length.
*/
`timescale 1ns/10ps
`default_nettype none
module card_model (
  input  wire logic        clk,
  input  wire logic        oeN,
  input  wire logic        iordN,
  input  wire logic        regN,
  input  wire logic        dma,
  input  wire logic        busy,
  input  wire logic        irq,
  input  wire logic        dmaReq,
  input  wire logic [7:0]  waitLen,
  input  wire logic [15:0] word,
  output logic      [15:0] dataOut,
  output logic             inpackN,
  output logic             readyIreq,
  output logic             waitN
);
  logic drive;
  int   n = 0;
  assign drive = !oeN || !iordN;
  // Released bus shows the inverse so a late sample cannot pass by luck
  assign dataOut = drive ? word : ~word;
  assign readyIreq = !(busy || irq);
  assign inpackN = dma ? !dmaReq : (iordN || regN);
  initial waitN = 1'b1;
  always @(posedge clk) begin
    n = drive ? n + 1 : 0;
    waitN <= !(drive && n < int'(waitLen));
  end
endmodule
`default_nettype wire

// *** sim/card_strobe_monitor.sv ***
/*
  Checker on the pins and status ports of the card strobe controller.
  Assumes the controller's declared ports; status lags the pins by 3 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module card_strobe_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic ce1N,
  input wire logic ce2N,
  input wire logic regN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic iordN,
  input wire logic iowrN,
  input wire logic inpackN,
  input wire logic readyIreq,
  input wire logic waitN,
  input wire logic cardReady,
  input wire logic cardIrq,
  input wire logic dmaRequest
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence take;
    cmdValid && cmdReady;
  endsequence
  sequence quiet;
    oeN && weN && iordN && iowrN;
  endsequence
  a_one_access: assert property (take |=> !cmdReady) else $error("second command taken");
  a_setup_gap: assert property (take |=> quiet[*4]) else $error("strobe within setup");
  a_lane_on: assert property (!(oeN && weN && iordN && iowrN) |-> !(ce1N && ce2N)) else $error("no lane");
  a_io_space: assert property (!(iordN && iowrN) |-> !regN) else $error("select high in io");
  a_strobe_len: assert property ($fell(iordN) |-> !iordN[*8]) else $error("short read strobe");
  a_oe_we: assert property (!oeN |-> weN) else $error("both memory strobes low");
  a_wait_hold: assert property ($rose(oeN) |-> $past(waitN, 4)) else $error("strobe ended in wait");
  a_ready_map: assert property ($rose(cardReady) |-> $past(readyIreq, 3)) else $error("bad ready");
  a_irq_map: assert property ($rose(cardIrq) |-> !$past(readyIreq, 3)) else $error("bad irq");
  a_dma_req: assert property ($rose(dmaRequest) |-> !$past(inpackN, 3)) else $error("bad request");
endmodule
bind card_strobe_ctrl card_strobe_monitor i_card_strobe_monitor (.ref_clk(ref_clk), .rst(rst),
  .cmdValid(cmdValid), .cmdReady(cmdReady), .ce1N(ce1N), .ce2N(ce2N), .regN(regN), .oeN(oeN),
  .weN(weN), .iordN(iordN), .iowrN(iowrN), .inpackN(inpackN), .readyIreq(readyIreq), .waitN(waitN),
  .cardReady(cardReady), .cardIrq(cardIrq), .dmaRequest(dmaRequest));
`default_nettype wire

// *** sim/tb.sv ***
/*
  Self-checking bench for the card strobe controller with a card model.
  Assumes a 125 MHz clock and inputs driven 1 ns after each rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        ref_clk, rst, cmdValid, cmdReady, cmdWide, cmdOdd, cmdLast, rdValid, rdReady;
  logic        memOnly, dmaMode, ce1N, ce2N, regN, oeN, weN, iordN, iowrN, cardDataOeN, waitTimeout;
  logic        inpackN, readyIreq, waitN, cardReady, cardIrq, dmaRequest, ioAcked, busy, irq, dmaReq;
  logic [2:0]  cmdKind;
  logic [7:0]  waitLen;
  logic [15:0] cmdData, rdData, cardDataIn, cardDataOut, word;
  wire         quiet = oeN & weN & iordN & iowrN;
  int          fail_count, cmp_count, len, gap;

  card_strobe_ctrl i_card_strobe_ctrl (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdWide(cmdWide), .cmdOdd(cmdOdd), .cmdLast(cmdLast),
    .cmdData(cmdData), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .memOnly(memOnly),
    .dmaMode(dmaMode), .ce1N(ce1N), .ce2N(ce2N), .regN(regN), .oeN(oeN), .weN(weN), .iordN(iordN),
    .iowrN(iowrN), .cardDataIn(cardDataIn), .cardDataOut(cardDataOut), .cardDataOeN(cardDataOeN),
    .inpackN(inpackN), .readyIreq(readyIreq), .waitN(waitN), .cardReady(cardReady),
    .cardIrq(cardIrq), .dmaRequest(dmaRequest), .ioAcked(ioAcked), .waitTimeout(waitTimeout));
  card_model i_card_model (.clk(ref_clk), .oeN(oeN), .iordN(iordN), .regN(regN), .dma(dmaMode),
    .busy(busy), .irq(irq), .dmaReq(dmaReq), .waitLen(waitLen), .word(word), .dataOut(cardDataIn),
    .inpackN(inpackN), .readyIreq(readyIreq), .waitN(waitN));

  always #4 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic hang;
    fail_count++;
    test_done;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic access(input logic [2:0] k, input logic w, input logic o, input logic l,
                        input logic [15:0] d);
    int         i;
    logic [6:0] e;
    e = {w ? 2'b00 : (o ? 2'b10 : 2'b01), k < 3'h2, !(k == 3'h0 || k == 3'h2 || (k == 3'h6 && l)),
         !(k == 3'h1 || k == 3'h3 || (k == 3'h7 && l)), !(k == 3'h4 || k == 3'h6), !(k == 3'h5 || k == 3'h7)};
    for (i = 0; i < 300 && cmdReady !== 1'b1; i++) tick(1);
    if (i == 300) hang;
    cmdValid = 1'b1;
    cmdKind = k;
    cmdWide = w;
    cmdOdd = o;
    cmdLast = l;
    cmdData = d;
    tick(1);
    cmdValid = 1'b0;
    for (i = 0; i < 300 && quiet !== 1'b0; i++) tick(1);
    if (i == 300) hang;
    gap = i;
    tick(2);
    check({ce1N, ce2N, regN, oeN, weN, iordN, iowrN}, e);
    check({cardDataOeN, k[0] ? cardDataOut : d}, {!k[0], d});
    for (len = 2; len < 3000 && quiet === 1'b0; len++) tick(1);
    if (len == 3000) hang;
  endtask

  task automatic pop(input logic [15:0] exp);
    int i;
    for (i = 0; i < 300 && rdValid !== 1'b1; i++) tick(1);
    if (i == 300) hang;
    check(rdData, exp);
    rdReady = 1'b1;
    tick(1);
    rdReady = 1'b0;
    // Let an edge pass so a following pop never re-raises ready in the same step
    tick(1);
  endtask

  task automatic t_kinds;
    logic [3:0] k;
    for (k = 0; k < 8; k++) begin
      word = 16'ha5c0 + k;
      access(k[2:0], !k[0], k[1], 1'b1, 16'h3c00 + k);
      check(len < 40, 1);
      if (!k[0]) pop(word);
      if (k == 4'h4) check(ioAcked, 1);
    end
  endtask

  task automatic t_status;
    busy = 1'b1;
    tick(6);
    check({cardReady, cardIrq}, 2'b00);
    // A busy memory card must hold off the write strobe until ready returns
    fork
      access(3'h1, 1'b1, 1'b0, 1'b0, 16'h6d2b);
      begin
        tick(30);
        busy = 1'b0;
      end
    join
    check(gap > 20, 1);
    busy = 1'b0;
    tick(6);
    check({cardReady, cardIrq}, 2'b10);
    memOnly = 1'b0;
    tick(6);
    check({cardReady, cardIrq}, 2'b00);
    irq = 1'b1;
    tick(6);
    check({cardReady, cardIrq}, 2'b01);
    irq = 1'b0;
    memOnly = 1'b1;
    tick(6);
  endtask

  task automatic t_dma;
    dmaMode = 1'b1;
    dmaReq = 1'b1;
    tick(6);
    check(dmaRequest, 1);
    word = 16'h5a17;
    access(3'h6, 1'b1, 1'b0, 1'b0, 16'h0000);
    pop(word);
    dmaReq = 1'b0;
    tick(6);
    check(dmaRequest, 0);
    dmaMode = 1'b0;
  endtask

  task automatic t_wait;
    waitLen = 8'h28;
    word = 16'hc3e1;
    access(3'h0, 1'b1, 1'b0, 1'b0, 16'h0000);
    check(len > 40, 1);
    check(waitTimeout, 0);
    pop(word);
    waitLen = 8'h00;
  endtask

  task automatic t_fill;
    logic [4:0] i;
    for (i = 0; i < 17; i++) begin
      word = 16'h0100 + i;
      access(3'h0, 1'b1, 1'b0, 1'b0, 16'h0000);
    end
    tick(40);
    check(cmdReady, 0);
    for (i = 0; i < 17; i++) pop(16'h0100 + i);
    tick(2);
    check(rdValid, 0);
  endtask

  initial begin
    {ref_clk, cmdValid, cmdWide, cmdOdd, cmdLast, rdReady, dmaMode, busy, irq, dmaReq} = '0;
    {rst, memOnly} = 2'b11;
    {cmdKind, waitLen, cmdData, word} = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    tick(2);
    t_kinds;
    t_status;
    t_dma;
    t_wait;
    t_fill;
    test_done;
  end
endmodule
`default_nettype wire

// *** src/card_strobe_ctrl.sv ***
/*
  Host-side control strobe sequencer for one 16-bit card socket.
  Takes one access command at a time, runs setup, strobe and hold phases
  on the card pins, and queues read data in a 16-word FIFO.
  Assumes card pins are asynchronous to ref_clk, all strobes active low,
  and the user command port is on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module card_strobe_ctrl #(
  parameter int DATA_W     = pccard_pkg::DATA_W,
  parameter int FIFO_DEPTH = pccard_pkg::FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Command port
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire logic [2:0]        cmdKind,
  input  wire logic              cmdWide,
  input  wire logic              cmdOdd,
  input  wire logic              cmdLast,
  input  wire logic [DATA_W-1:0] cmdData,
  // Read data out of the FIFO
  output logic                   rdValid,
  input  wire logic              rdReady,
  output logic      [DATA_W-1:0] rdData,
  // Socket configuration
  input  wire logic              memOnly,
  input  wire logic              dmaMode,
  // Card pins
  output logic                   ce1N,
  output logic                   ce2N,
  output logic                   regN,
  output logic                   oeN,
  output logic                   weN,
  output logic                   iordN,
  output logic                   iowrN,
  input  wire logic [DATA_W-1:0] cardDataIn,
  output logic      [DATA_W-1:0] cardDataOut,
  output logic                   cardDataOeN,
  input  wire logic              inpackN,
  input  wire logic              readyIreq,
  input  wire logic              waitN,
  // Status
  output logic                   cardReady,
  output logic                   cardIrq,
  output logic                   dmaRequest,
  output logic                   ioAcked,
  output logic                   waitTimeout
);

  pccard_pkg::state_t           state;
  logic [pccard_pkg::CNT_W-1:0] cnt;
  logic [pccard_pkg::WAIT_W-1:0] waitCnt;
  pccard_pkg::cmd_t             kind;
  logic                         wide;
  logic                         odd;
  logic                         last;
  logic [DATA_W-1:0]            wrData;

  logic [2:0]                   pinSync;
  logic [DATA_W-1:0]            dataSync;
  logic                         inpackSync;
  logic                         readySync;
  logic                         waitFree;

  logic                         pushValid;
  logic [DATA_W-1:0]            pushData;
  logic                         fifoInReady;
  logic                         fifoOutValid;
  logic                         fifoOutReady;
  logic [DATA_W-1:0]            fifoOutData;

  logic                         accept;
  logic                         strobeDone;
  logic                         waitExpired;
  logic                         leaveStrobe;
  logic                         memBusy;
  logic                         active;
  logic                         strobeOn;

  function automatic logic isRead(input pccard_pkg::cmd_t k);
    return (k == pccard_pkg::CMD_MEM_RD) || (k == pccard_pkg::CMD_ATTR_RD) ||
           (k == pccard_pkg::CMD_IO_RD) || (k == pccard_pkg::CMD_DMA_TO_HOST);
  endfunction

  function automatic logic isMemWrite(input pccard_pkg::cmd_t k);
    return (k == pccard_pkg::CMD_MEM_WR) || (k == pccard_pkg::CMD_ATTR_WR);
  endfunction

  function automatic logic isMemRead(input pccard_pkg::cmd_t k);
    return (k == pccard_pkg::CMD_MEM_RD) || (k == pccard_pkg::CMD_ATTR_RD);
  endfunction

  // Card inputs and read data are asynchronous to ref_clk
  pin_sync #(
    .WIDTH (3),
    .INIT  (pccard_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clk    (ref_clk),
    .rst    (rst),
    .pinIn  ({inpackN, readyIreq, waitN}),
    .pinOut (pinSync)
  );

  pin_sync #(
    .WIDTH (DATA_W),
    .INIT  (pccard_pkg::DATA_RESET)
  ) u_data_sync (
    .clk    (ref_clk),
    .rst    (rst),
    .pinIn  (cardDataIn),
    .pinOut (dataSync)
  );

  assign inpackSync = pinSync[2];
  assign readySync  = pinSync[1];
  assign waitFree   = pinSync[0];

  assign accept      = (state == pccard_pkg::ST_IDLE) && cmdValid && cmdReady;
  assign strobeDone  = (state == pccard_pkg::ST_STROBE) && (cnt <= 8'h01);
  assign waitExpired = (waitCnt >= pccard_pkg::WAIT_MAX_CYC);
  // A stuck wait line would hang the socket, so the stretch is bounded
  assign leaveStrobe = strobeDone && (waitFree || waitExpired);
  // Memory writes wait for a busy memory card to finish its last one
  assign memBusy     = memOnly && !readySync;
  assign active      = (state != pccard_pkg::ST_IDLE);
  assign strobeOn    = (state == pccard_pkg::ST_STROBE);

  // Access sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= pccard_pkg::ST_IDLE;
      cnt      <= '0;
      cmdReady <= 1'b0;
    end else begin
      unique case (state)
        pccard_pkg::ST_IDLE: begin
          if (accept) begin
            state    <= pccard_pkg::ST_SETUP;
            cnt      <= pccard_pkg::SETUP_CYC;
            cmdReady <= 1'b0;
          end else begin
            // A pending push may take the last free slot
            cmdReady <= fifoInReady && !pushValid;
          end
        end
        pccard_pkg::ST_SETUP: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else if (!(isMemWrite(kind) && memBusy)) begin
            state <= pccard_pkg::ST_STROBE;
            cnt   <= pccard_pkg::STROBE_CYC;
          end
        end
        pccard_pkg::ST_STROBE: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else if (leaveStrobe) begin
            state <= pccard_pkg::ST_HOLD;
            cnt   <= pccard_pkg::HOLD_CYC;
          end
        end
        pccard_pkg::ST_HOLD: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else begin
            state <= pccard_pkg::ST_IDLE;
          end
        end
        default: begin
          state    <= pccard_pkg::ST_IDLE;
          cnt      <= '0;
          cmdReady <= 1'b0;
        end
      endcase
    end
  end

  // Wait stretch counter, restarted for every strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitCnt <= '0;
    end else if (strobeDone && !waitFree && !waitExpired) begin
      waitCnt <= waitCnt + 16'h0001;
    end else if (!strobeOn) begin
      waitCnt <= '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitTimeout <= 1'b0;
    end else if (leaveStrobe && !waitFree) begin
      waitTimeout <= 1'b1;
    end else if (accept) begin
      waitTimeout <= 1'b0;
    end
  end

  // Command held for the whole access
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kind   <= pccard_pkg::CMD_MEM_RD;
      wide   <= 1'b0;
      odd    <= 1'b0;
      last   <= 1'b0;
      wrData <= pccard_pkg::DATA_RESET;
    end else if (accept) begin
      kind   <= pccard_pkg::cmd_t'(cmdKind);
      wide   <= cmdWide;
      odd    <= cmdOdd;
      last   <= cmdLast;
      wrData <= cmdData;
    end
  end

  // Card pins, registered one cycle behind the sequencer state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ce1N        <= 1'b1;
      ce2N        <= 1'b1;
      regN        <= 1'b1;
      oeN         <= 1'b1;
      weN         <= 1'b1;
      iordN       <= 1'b1;
      iowrN       <= 1'b1;
      cardDataOut <= pccard_pkg::DATA_RESET;
      cardDataOeN <= 1'b1;
    end else begin
      ce1N  <= !(active && (wide || !odd));
      ce2N  <= !(active && (wide || odd));
      // Attribute, I/O and DMA all run with attribute select low
      regN  <= !(active && (kind != pccard_pkg::CMD_MEM_RD) &&
                 (kind != pccard_pkg::CMD_MEM_WR));
      oeN   <= !(strobeOn && (isMemRead(kind) ||
                 (kind == pccard_pkg::CMD_DMA_TO_HOST && last)));
      weN   <= !(strobeOn && (isMemWrite(kind) ||
                 (kind == pccard_pkg::CMD_DMA_TO_CARD && last)));
      iordN <= !(strobeOn && ((kind == pccard_pkg::CMD_IO_RD) ||
                 (kind == pccard_pkg::CMD_DMA_TO_HOST)));
      iowrN <= !(strobeOn && ((kind == pccard_pkg::CMD_IO_WR) ||
                 (kind == pccard_pkg::CMD_DMA_TO_CARD)));
      cardDataOut <= wrData;
      cardDataOeN <= !(active && !isRead(kind));
    end
  end

  // Read data captured as the strobe ends, held until the FIFO takes it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pushValid <= 1'b0;
      pushData  <= pccard_pkg::DATA_RESET;
    end else if (leaveStrobe && isRead(kind)) begin
      pushValid <= 1'b1;
      pushData  <= dataSync;
    end else if (fifoInReady) begin
      pushValid <= 1'b0;
    end
  end

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (ref_clk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (fifoInReady),
    .inData   (pushData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Output register keeps rdData straight from a flip-flop
  assign fifoOutReady = !rdValid || rdReady;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData  <= pccard_pkg::DATA_RESET;
    end else if (fifoOutReady) begin
      rdValid <= fifoOutValid;
      rdData  <= fifoOutData;
    end
  end

  // Acknowledge sampled at strobe end tells whether the I/O read was answered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ioAcked <= 1'b0;
    end else if (leaveStrobe && kind == pccard_pkg::CMD_IO_RD) begin
      ioAcked <= !inpackSync;
    end
  end

  // Shared input meanings follow the socket configuration
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cardReady  <= 1'b0;
      cardIrq    <= 1'b0;
      dmaRequest <= 1'b0;
    end else begin
      cardReady  <= memOnly && readySync;
      cardIrq    <= !memOnly && !readySync;
      dmaRequest <= dmaMode && !inpackSync;
    end
  end

endmodule

`default_nettype wire

// *** src/pin_sync.sv ***
/*
  Two-stage synchroniser for a group of asynchronous card pins.
  Assumes each bit is an independent level; multi-bit groups may skew by a cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int                 WIDTH = 1,
  parameter logic [WIDTH-1:0]   INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      pinOut <= INIT;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end

endmodule

`default_nettype wire

// *** src/word_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; one clock for both sides.
*/
`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             full;
  logic             empty;

  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty    = (wrPtr == rdPtr);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire
